// ---- src/qes_pkg.sv ----
// package: register map, field layout and codes of the encoder block
package qes_pkg;
    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS  = 8'h00; // event flags + enables
    localparam logic [7:0] OFS_POS_CNT = 8'h04; // live position counter
    localparam logic [7:0] OFS_POS_HLD = 8'h08; // position holding
    localparam logic [7:0] OFS_VEL_CNT = 8'h0C; // velocity counter
    localparam logic [7:0] OFS_GE_CMP  = 8'h10; // greater-equal value
    localparam logic [7:0] OFS_LE_CMP  = 8'h14; // less-equal value
    localparam logic [7:0] OFS_CTRL    = 8'h18; // init mode field

    // ---------------------------------------------------------------
    // status register layout: flag at odd bit, enable just below
    // ---------------------------------------------------------------
    localparam int NUM_EVT      = 7;
    localparam int EVT_INDEX    = 0; // flag bit 1, enable bit 0
    localparam int EVT_HOME     = 1; // flag bit 3, enable bit 2
    localparam int EVT_VEL_OVF  = 2; // flag bit 5, enable bit 4
    localparam int EVT_HOMING   = 3; // flag bit 7, enable bit 6
    localparam int EVT_POS_OVF  = 4; // flag bit 9, enable bit 8
    localparam int EVT_LOW_CMP  = 5; // flag bit 11, enable bit 10
    localparam int EVT_HIGH_CMP = 6; // flag bit 13, enable bit 12
    localparam int STATUS_W     = 14;
    localparam int MODE_W       = 3;

    // ---------------------------------------------------------------
    // reset values and limits
    // ---------------------------------------------------------------
    localparam logic [15:0] CNT_RESET  = 16'h0000;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] VEL_MAX    = 16'h7FFF;
    localparam logic [15:0] VEL_MIN    = 16'h8000;
    localparam logic [15:0] CNT_STEP   = 16'h0001;
    localparam logic [6:0]  EVT_NONE   = 7'h00;

    // position initialisation modes
    typedef enum logic [MODE_W-1:0] {
        PIM_FREE     = 3'b000,
        PIM_RSV1     = 3'b001,
        PIM_RSV2     = 3'b010,
        PIM_HOME_IDX = 3'b011, // home arms, next index reloads
        PIM_HOME     = 3'b100, // home edge reloads directly
        PIM_RSV5     = 3'b101,
        PIM_RSV6     = 3'b110,
        PIM_RSV7     = 3'b111
    } qes_mode_t;
endpackage

// ---- src/qes_top.sv ----
// encoder event status, position hold and velocity counter block
// Function
// - high-compare flag sets when count >= value
// - low-compare flag sets when count <= value
// - position overflow flag sets on counter wrap
// - homing flag sets when counter reinitialised
// - homing flag only in modes 011, 100
// - velocity overflow flag sets on counter wrap
// - home event flag sets on home edge
// - flags hardware-set, reset zero, write-one clear
// - each flag has read-write enable bit
// - homing enable sits at bit six
// - velocity overflow enable sits at bit four
// - 16-bit holding register reads/writes position
// - 16-bit velocity counter, software read-write
//
// Local design decisions: the placing of the registers and register access over AHB-Lite.
module qes_top
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic        enc_index,
    input  wire logic        enc_home,
    output logic             irq
);
    import qes_pkg::*;

    // ---------------------------------------------------------------
    // state of the whole block
    // ---------------------------------------------------------------
    // everything the block remembers sits in one struct so that a
    // single register process and a single reset cover all of it;
    // adding a field cannot leave a flop without its reset value
    typedef struct packed {
        logic [3:0]        sync1;    // first stage, pins a,b,idx,home
        logic [3:0]        sync2;    // second stage
        logic [3:0]        prev;     // last sampled stage-two value
        logic              dph_wr;   // pending write data phase
        logic [7:0]        dph_addr; // its word address
        logic [31:0]       rdata;    // registered read data
        logic [6:0]        flag;     // sticky event flags
        logic [6:0]        en;       // per-event interrupt enables
        logic [15:0]       pos;      // position counter
        logic [15:0]       hold;     // position holding register
        logic [15:0]       vel;      // velocity counter
        logic [15:0]       ge_val;   // greater-equal compare value
        logic [15:0]       le_val;   // less-equal compare value
        logic [MODE_W-1:0] mode;     // position init mode
        logic              armed;    // home seen, waiting for index
        logic              irq;      // registered interrupt
    } qes_state_t;

    qes_state_t s_q;  // registered state
    qes_state_t s_d;  // next state

    logic [15:0] stat_view; // status register as software sees it

    // ---------------------------------------------------------------
    // status view: flags at odd bits, enables at even bits
    // ---------------------------------------------------------------
    always_comb
    begin
        stat_view = '0;
        for (int i = 0; i < NUM_EVT; i++)
        begin
            stat_view[2*i+1] = s_q.flag[i];
            stat_view[2*i]   = s_q.en[i];
        end
    end

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb
    begin
        logic        a_now;
        logic        b_now;
        logic        step;
        logic        up;
        logic        idx_rise;
        logic        home_rise;
        logic        reinit;
        logic        addr_ok;
        logic        wr_now;
        logic [6:0]  set;
        logic [6:0]  clr;
        logic [15:0] rd;

        // default: hold every field; the branches below only touch
        // what the current cycle actually changes
        s_d       = s_q;
        set       = EVT_NONE;
        clr       = EVT_NONE;
        rd        = '0;
        reinit    = 1'b0;

        // the pins come from an unrelated clock; nothing past the
        // second stage may look at the first, or a metastable value
        // could reach the counters
        // two-flop synchronisers on the encoder pins
        s_d.sync1 = {enc_home, enc_index, enc_b, enc_a};
        s_d.sync2 = s_q.sync1;
        s_d.prev  = s_q.sync2;

        // x4 quadrature decode; both inputs moving at once is a
        // glitch or a lost edge, and is ignored rather than guessed
        a_now     = s_q.sync2[0];
        b_now     = s_q.sync2[1];
        step      = (a_now ^ s_q.prev[0]) ^ (b_now ^ s_q.prev[1]);
        up        = s_q.prev[0] ^ b_now;
        idx_rise  = s_q.sync2[2] & ~s_q.prev[2];
        home_rise = s_q.sync2[3] & ~s_q.prev[3];

        // overflow is judged on the old count, so the flag and the
        // wrapped value land on the same edge
        // position counter with wrap detection
        if (step)
        begin
            if (up)
            begin
                s_d.pos = s_q.pos + CNT_STEP;
                if (s_q.pos == CNT_MAX)
                    set[EVT_POS_OVF] = 1'b1;
            end
            else
            begin
                s_d.pos = s_q.pos - CNT_STEP;
                if (s_q.pos == CNT_RESET)
                    set[EVT_POS_OVF] = 1'b1;
            end
        end

        // the velocity counter follows the same steps as the position
        // counter; software is expected to read and zero it per period
        // velocity counter, signed, wraps at the signed limits
        if (step)
        begin
            if (up)
            begin
                s_d.vel = s_q.vel + CNT_STEP;
                if (s_q.vel == VEL_MAX)
                    set[EVT_VEL_OVF] = 1'b1;
            end
            else
            begin
                s_d.vel = s_q.vel - CNT_STEP;
                if (s_q.vel == VEL_MIN)
                    set[EVT_VEL_OVF] = 1'b1;
            end
        end

        // only rising edges count: a pin held high after a pulse
        // must not set the flag again once software has cleared it
        // index and home events
        if (idx_rise)
            set[EVT_INDEX] = 1'b1;
        if (home_rise)
            set[EVT_HOME] = 1'b1;

        // homing: only the two homing modes ever reload the counter
        unique case (qes_mode_t'(s_q.mode))
            PIM_HOME_IDX:
            begin
                if (home_rise)
                    s_d.armed = 1'b1;
                if (s_q.armed && idx_rise)
                begin
                    reinit    = 1'b1;
                    s_d.armed = 1'b0;
                end
            end
            PIM_HOME:
            begin
                s_d.armed = 1'b0;
                reinit    = home_rise;
            end
            default:
            begin
                // other modes leave the counter free running
                s_d.armed = 1'b0;
            end
        endcase
        if (reinit)
        begin
            s_d.pos         = CNT_RESET;
            set[EVT_HOMING] = 1'b1;
        end

        // the compare flags are set again every cycle the relation
        // holds, so a clear only sticks once the count has moved away
        // compares use the count as it stands this cycle
        if (s_q.pos >= s_q.ge_val)
            set[EVT_HIGH_CMP] = 1'b1;
        if (s_q.pos <= s_q.le_val)
            set[EVT_LOW_CMP] = 1'b1;

        // -----------------------------------------------------------
        // bus: address phase, zero wait state
        // -----------------------------------------------------------
        addr_ok    = hsel & hready & htrans[1];
        wr_now     = addr_ok & hwrite;
        s_d.dph_wr = wr_now;
        if (addr_ok)
            s_d.dph_addr = {haddr[7:2], 2'b00};

        // read data captured at the address phase
        if (addr_ok && !hwrite)
        begin
            unique case ({haddr[7:2], 2'b00})
                OFS_STATUS:  rd = stat_view;
                OFS_POS_CNT:
                begin
                    // a read snapshots the count into the holder
                    rd       = s_q.pos;
                    s_d.hold = s_q.pos;
                end
                OFS_POS_HLD: rd = s_q.hold;
                OFS_VEL_CNT: rd = s_q.vel;
                OFS_GE_CMP:  rd = s_q.ge_val;
                OFS_LE_CMP:  rd = s_q.le_val;
                OFS_CTRL:    rd = {13'h0000, s_q.mode};
                default:     rd = '0; // unmapped reads zero
            endcase
            s_d.rdata = {16'h0000, rd};
        end

        // the write lands at the end of the data phase, after the
        // counters above, so a software load wins over a step
        // write data phase; software writes beat counting
        if (s_q.dph_wr)
        begin
            unique case (s_q.dph_addr)
                OFS_STATUS:
                begin
                    for (int i = 0; i < NUM_EVT; i++)
                    begin
                        clr[i]   = hwdata[2*i+1];
                        s_d.en[i] = hwdata[2*i];
                    end
                end
                OFS_POS_CNT:
                    s_d.pos = s_q.hold; // loads from holder
                OFS_POS_HLD:
                    s_d.hold = hwdata[15:0];
                OFS_VEL_CNT:
                    s_d.vel = hwdata[15:0];
                OFS_GE_CMP:
                    s_d.ge_val = hwdata[15:0];
                OFS_LE_CMP:
                    s_d.le_val = hwdata[15:0];
                OFS_CTRL:
                    s_d.mode = hwdata[MODE_W-1:0];
                default:
                begin
                    // unmapped writes are dropped
                end
            endcase
        end

        // sticky flags: a set in the clear cycle wins
        s_d.flag = (s_q.flag & ~clr) | set;

        // built from the next flags and enables so that the line
        // moves on the same edge as the status bits it reflects
        // one level interrupt from enabled flags
        s_d.irq = |(s_d.flag & s_d.en);
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // every output comes straight from a flop or a constant, so no
    // bus input can ripple through to the data or interrupt lines
    assign hrdata    = s_q.rdata;
    assign hreadyout = 1'b1; // never stretches a transfer
    assign hresp     = 1'b0; // always OKAY
    assign irq       = s_q.irq;
endmodule

// ---- dv/qes_enc_model.sv ----
// quadrature encoder pin model: a/b phases, index and home pulses
module qes_enc_model
(
    input  wire logic hclk,
    input  wire logic step,
    input  wire logic dir_up,
    input  wire logic idx_req,
    input  wire logic home_req,
    output logic      enc_a,
    output logic      enc_b,
    output logic      enc_index,
    output logic      enc_home
);
    timeunit 1ns;
    timeprecision 1ns;
    // -----------------------------------------------------------
    // phase walk
    // -----------------------------------------------------------
    logic [1:0] ph_q = 2'h0; // 00 01 11 10 is the up direction
    // one phase move per step request, so one count each
    always_ff @(posedge hclk)
    begin
        if (step)
            ph_q <= dir_up ? ph_q + 2'h1 : ph_q - 2'h1;
    end
    // only one of a and b ever changes, never both in one move
    always_comb
    begin
        enc_a     = ph_q[1];
        enc_b     = ph_q[1] ^ ph_q[0];
        enc_index = idx_req;
        enc_home  = home_req;
    end
endmodule

// ---- dv/qes_top_asserts.sv ----
// assertion checker on the bus and interrupt ports of the block
module qes_top_asserts
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        enc_a,
    input wire logic        enc_b,
    input wire logic        enc_index,
    input wire logic        enc_home,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import qes_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // -----------------------------------------------------------
    // helper: data-phase markers and age of last pin change
    // -----------------------------------------------------------
    logic       acc;     // address phase taken this edge
    logic       wr_q;    // any write in data phase
    logic       wr_st_q; // status write in data phase
    logic       rd_st_q; // status read in data phase
    logic       rd_un_q; // unmapped read in data phase
    logic [3:0] pins_q;  // pins seen last edge
    logic [2:0] age_q;   // edges since pins moved, saturates
    assign acc = hsel & hready & htrans[1];
    // age saturates at seven so it never wraps back to young
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            {wr_q, wr_st_q, rd_st_q, rd_un_q, pins_q, age_q} <= '0;
        else
        begin
            wr_q    <= acc & hwrite;
            wr_st_q <= acc & hwrite & (haddr[7:0] == OFS_STATUS);
            rd_st_q <= acc & !hwrite & (haddr[7:0] == OFS_STATUS);
            rd_un_q <= acc & !hwrite & (haddr[7:2] > OFS_CTRL[7:2]);
            pins_q  <= {enc_a, enc_b, enc_index, enc_home};
            if (pins_q != {enc_a, enc_b, enc_index, enc_home})
                age_q <= 3'h0;
            else if (age_q != 3'h7)
                age_q <= age_q + 3'h1;
        end
    end
    // -----------------------------------------------------------
    // assertions
    // -----------------------------------------------------------
    a_ready_always: assert property (hreadyout)
        else $error("hreadyout low");
    a_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    a_upper_zero: assert property (hrdata[31:16] == 16'h0000)
        else $error("hrdata upper half not zero");
    a_read_holds: assert property (!$past(acc && !hwrite) |-> $stable(hrdata))
        else $error("hrdata moved without a read");
    a_unmapped_zero: assert property (rd_un_q |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_status_rsv: assert property (rd_st_q |-> hrdata[15:14] == 2'h0)
        else $error("status bits 15:14 not zero");
    a_irq_sticky: assert property (irq && !wr_st_q |=> irq)
        else $error("irq dropped without status write");
    a_irq_cause: assert property ($rose(irq) |->
        (age_q < 3'h7) || $past(wr_q) || $past(wr_q, 2) || $past(wr_q, 3))
        else $error("irq rose with no event or write");
    c_irq_cleared: cover property (irq ##1 !irq);
    c_irq_raised: cover property ($rose(irq));
    c_unmapped: cover property (rd_un_q);
endmodule

bind qes_top qes_top_asserts u_chk (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .enc_a,
    .enc_b, .enc_index, .enc_home, .irq);

// ---- dv/testbench.sv ----
// self-checking bench: register bus, encoder events and interrupt
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    err_count++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import qes_pkg::*;
    // -----------------------------------------------------------
    // signals
    // -----------------------------------------------------------
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
    logic        hwrite = 1'b0, step = 1'b0, up = 1'b1;
    logic        idx = 1'b0, home = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2; // whole words only
    logic        hreadyout, hresp, irq, enc_a, enc_b, enc_index, enc_home;
    int          err_count = 0, checks_done = 0;
    qes_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .enc_a, .enc_b, .enc_index, .enc_home, .irq);
    qes_enc_model u_enc (.hclk, .step, .dir_up(up), .idx_req(idx),
        .home_req(home), .enc_a, .enc_b, .enc_index, .enc_home);
    initial forever #5 hclk = ~hclk;
    // -----------------------------------------------------------
    // bus tasks and expectation
    // -----------------------------------------------------------
    // address phase held until ready, then data phase until ready
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input string n, input logic [7:0] a,
        input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(n, e, q)
    endtask
    // each step moves the phase once; settle time covers sync delay
    task automatic steps(input int k, input logic dir);
        repeat (k)
        begin
            step <= 1'b1; up <= dir;
            @(posedge hclk) step <= 1'b0;
            repeat (3) @(posedge hclk);
        end
        repeat (6) @(posedge hclk);
    endtask
    // flags land on odd bits, enables on the even bit below each
    function automatic logic [31:0] st(input logic [6:0] f,
        input logic [6:0] e);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < NUM_EVT; i++)
        begin
            r[2*i+1] = f[i];
            r[2*i]   = e[i];
        end
        return r;
    endfunction
    task automatic report_and_stop;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog: whole run is under a thousand cycles, limit is 20000
    initial
    begin
        #200000;
        err_count++;
        report_and_stop();
    end
    // -----------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------
    initial
    begin
        logic [31:0] d, e;
        int g, n, hm;
        d = $urandom(75341);
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // zero count meets both zero compare values straight away
        rd("hold", OFS_POS_HLD, 32'h0);
        rd("vel", OFS_VEL_CNT, 32'h0);
        rd("status", OFS_STATUS, st(7'h60, 7'h00));
        for (int i = 0; i < 4; i++)
        begin
            d = $urandom & 32'hFFFF;
            e = $urandom & 32'hFFFF;
            wr(OFS_POS_HLD, d);
            wr(OFS_VEL_CNT, e);
            rd("hold", OFS_POS_HLD, d);
            rd("vel", OFS_VEL_CNT, e);
        end
        wr(8'h1C, 32'hFFFF);
        rd("unmapped", 8'h1C, 32'h0);
        d = $urandom & 32'h7F;
        wr(OFS_STATUS, st(7'h00, d[6:0]));
        rd("enables", OFS_STATUS, st(7'h60, d[6:0]));
        // compare: count climbs from zero past or short of the value
        g = 1 + $urandom % 20;
        n = $urandom % 21;
        wr(OFS_VEL_CNT, 32'h0);
        wr(OFS_GE_CMP, g);
        wr(OFS_LE_CMP, 32'hFFFF);
        wr(OFS_STATUS, st(7'h7F, 7'h00));
        steps(n, 1'b1);
        rd("count", OFS_POS_CNT, n);
        rd("hold copy", OFS_POS_HLD, n);
        rd("cmp", OFS_STATUS, st({n >= g, 6'h20}, 7'h00));
        // both counters wrap on one up step
        wr(OFS_GE_CMP, 32'hFFFF);
        wr(OFS_POS_HLD, 32'hFFFF);
        wr(OFS_POS_CNT, 32'h0);
        wr(OFS_VEL_CNT, 32'h7FFF);
        wr(OFS_STATUS, st(7'h7F, 7'h10));
        @(negedge hclk) `CHK("irq", 1'b0, irq)
        @(posedge hclk);
        steps(1, 1'b1);
        rd("ovf", OFS_STATUS, st(7'h74, 7'h10));
        `CHK("irq", 1'b1, irq)
        rd("vel wrap", OFS_VEL_CNT, 32'h8000);
        wr(OFS_STATUS, st(7'h00, 7'h00));
        @(negedge hclk) `CHK("irq masked", 1'b0, irq)
        @(posedge hclk);
        wr(OFS_STATUS, st(7'h10, 7'h10));
        rd("cleared", OFS_STATUS, st(7'h64, 7'h10));
        // both counters wrap on one down step
        wr(OFS_POS_HLD, 32'h0);
        wr(OFS_POS_CNT, 32'h0);
        wr(OFS_VEL_CNT, 32'h8000);
        wr(OFS_STATUS, st(7'h7F, 7'h00));
        steps(1, 1'b0);
        rd("down count", OFS_POS_CNT, 32'hFFFF);
        rd("down vel", OFS_VEL_CNT, 32'h7FFF);
        rd("down ovf", OFS_STATUS, st(7'h74, 7'h00));
        // every init mode: home pulse, then index pulse
        for (int m = 0; m < 8; m++)
        begin
            hm = (m == 3 || m == 4);
            wr(OFS_CTRL, m);
            wr(OFS_POS_HLD, 32'h5);
            wr(OFS_POS_CNT, 32'h0);
            wr(OFS_STATUS, st(7'h7F, 7'h00));
            home <= 1'b1;
            repeat (3) @(posedge hclk);
            home <= 1'b0;
            repeat (8) @(posedge hclk);
            idx <= 1'b1;
            repeat (3) @(posedge hclk);
            idx <= 1'b0;
            repeat (8) @(posedge hclk);
            rd("reinit", OFS_POS_CNT, hm ? 32'h0 : 32'h5);
            rd("homing", OFS_STATUS, st(7'h23 | (hm << 3), 7'h0));
        end
        report_and_stop();
    end
endmodule
